//--- logic/naeu_pkg.sv
// constants and types for the nibble arithmetic execution unit
// How it works
// - ram pointer is 7 bits (large) or 6 bits (small), selects operand
// - upper 3 (or 2) pointer bits form the row select field
// - lower 4 pointer bits form the digit select field
// - memory operand is the 4-bit ram word the pointer selects
// - 0x30 adds acc, carry, operand; sets carry; skips on carry
// - 0x31 adds operand to acc; carry untouched; never skips
// - 0x4a adds ten to acc; carry untouched; no skip
// - 0x5y adds immediate y; skips on carry; carry untouched; y=0 invalid
// - immediate field is 4 bits, unsigned 0 to 15
// - 0x10 adds inverted acc, operand, carry; sets carry; skips on carry
// - 0x40 inverts acc; carry untouched; no skip
// - 0x02 xors operand into acc; carry untouched; no skip
// - program counter is 11 bits; granted skip passes next instruction
package naeu_pkg;
    localparam int        NAEU_DATA_W       = 4;
    localparam int        NAEU_PTR_W_LARGE  = 7;
    localparam int        NAEU_PTR_W_SMALL  = 6;
    localparam int        NAEU_DIGIT_W      = 4;
    localparam int        NAEU_PC_W         = 11;
    localparam int        NAEU_RAM_DEPTH    = 128;
    localparam logic [7:0] NAEU_OP_ADD_CARRY_SKIP  = 8'h30;
    localparam logic [7:0] NAEU_OP_ADD             = 8'h31;
    localparam logic [7:0] NAEU_OP_ADD_TEN         = 8'h4a;
    localparam logic [3:0] NAEU_OP_ADD_IMM_HI      = 4'h5;
    localparam logic [7:0] NAEU_OP_COMPL_ADD_SKIP  = 8'h10;
    localparam logic [7:0] NAEU_OP_COMPLEMENT      = 8'h40;
    localparam logic [7:0] NAEU_OP_XOR             = 8'h02;
    localparam logic [7:0] NAEU_OP_CLEAR_ACC       = 8'h00;
    localparam logic [7:0] NAEU_OP_CLEAR_CARRY     = 8'h32;
    localparam logic [7:0] NAEU_OP_SET_CARRY       = 8'h22;
    localparam logic [7:0] NAEU_OP_NOP             = 8'h44;
    localparam logic [3:0] NAEU_TEN                = 4'ha;
    localparam logic [3:0] NAEU_ACC_RST            = 4'h0;
    localparam logic       NAEU_CARRY_RST          = 1'b0;
    localparam logic [10:0] NAEU_PC_RST            = 11'h000;
    typedef enum logic [1:0] {
        NAEU_ST_EXEC,
        NAEU_ST_SKIP
    } naeu_state_t;
endpackage

//--- logic/naeu_ram.sv
// 4-bit data ram with registered read and write port
`timescale 1ns/1ps
module naeu_ram (
    // clock
    input  wire logic       mclk,
    // write port
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [3:0] wr_data,
    // read port
    input  wire logic [6:0] rd_addr,
    output logic      [3:0] rd_data_ff
);
    import naeu_pkg::*;
    logic [3:0] mem [NAEU_RAM_DEPTH];
    // no reset on the array: software must load words before use
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule // naeu_ram

//--- logic/naeu_exec.sv
// execution unit for the arithmetic instruction group
`timescale 1ns/1ps
module naeu_exec #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // instruction from sequencer
    input  wire logic                   instr_valid,
    input  wire logic [7:0]             opcode,
    // ram pointer and ram loading port
    input  wire logic [6:0]             ram_ptr,
    input  wire logic                   ram_wr_en,
    input  wire logic [3:0]             ram_wr_data,
    // state out
    output logic [3:0]                  acc_ff,
    output logic                        carry_ff,
    output logic                        skip_req_ff,
    output logic [naeu_pkg::NAEU_PC_W-1:0] pc_ff,
    output logic                        illegal_ff
);
    import naeu_pkg::*;

    logic [6:0]  eff_ptr;
    logic [2:0]  ram_row_select;
    logic [3:0]  ram_digit_select;
    logic [3:0]  mem_operand;
    logic [3:0]  nxt_acc;
    logic        nxt_carry;
    logic        nxt_skip;
    logic        nxt_illegal;
    logic [10:0] nxt_pc;
    logic [4:0]  sum;
    naeu_state_t state_ff;
    naeu_state_t nxt_state;

    // small variant keeps only 6 pointer bits
    always_comb begin
        eff_ptr = SMALL_VARIANT ? {1'b0, ram_ptr[5:0]} : ram_ptr;
        ram_row_select   = eff_ptr[6:4];
        ram_digit_select = eff_ptr[3:0];
    end

    // operand read one cycle ahead: pointer must be stable before the opcode
    naeu_ram u_ram (
        .mclk       (mclk),
        .wr_en      (ram_wr_en),
        .wr_addr    ({ram_row_select, ram_digit_select}),
        .wr_data    (ram_wr_data),
        .rd_addr    ({ram_row_select, ram_digit_select}),
        .rd_data_ff (mem_operand)
    );

    always_comb begin
        nxt_acc     = acc_ff;
        nxt_carry   = carry_ff;
        nxt_skip    = 1'b0;
        nxt_illegal = 1'b0;
        nxt_state   = state_ff;
        nxt_pc      = pc_ff;
        sum         = 5'h00;
        if (instr_valid) begin
            nxt_pc = pc_ff + 11'h001;
            unique case (state_ff)
                NAEU_ST_SKIP: begin
                    // fetched but discarded, only pc advances
                    nxt_state = NAEU_ST_EXEC;
                end
                NAEU_ST_EXEC: begin
                    if (opcode[7:4] == NAEU_OP_ADD_IMM_HI) begin
                        // 4-bit unsigned immediate in low nibble
                        sum     = {1'b0, acc_ff} + {1'b0, opcode[3:0]};
                        nxt_acc = sum[3:0];
                        nxt_skip = sum[4];
                        nxt_illegal = (opcode[3:0] == 4'h0);
                    end else begin
                        case (opcode)
                            NAEU_OP_ADD_CARRY_SKIP: begin
                                sum = {1'b0, acc_ff} + {1'b0, mem_operand}
                                    + {4'h0, carry_ff};
                                nxt_acc   = sum[3:0];
                                nxt_carry = sum[4];
                                nxt_skip  = sum[4];
                            end
                            NAEU_OP_ADD: begin
                                sum = {1'b0, acc_ff} + {1'b0, mem_operand};
                                nxt_acc = sum[3:0];
                            end
                            NAEU_OP_ADD_TEN: begin
                                // decimal correction helper
                                nxt_acc = acc_ff + NAEU_TEN;
                            end
                            NAEU_OP_COMPL_ADD_SKIP: begin
                                sum = {1'b0, ~acc_ff} + {1'b0, mem_operand}
                                    + {4'h0, carry_ff};
                                nxt_acc   = sum[3:0];
                                nxt_carry = sum[4];
                                nxt_skip  = sum[4];
                            end
                            NAEU_OP_COMPLEMENT: begin
                                nxt_acc = ~acc_ff;
                            end
                            NAEU_OP_XOR: begin
                                nxt_acc = acc_ff ^ mem_operand;
                            end
                            NAEU_OP_CLEAR_ACC: begin
                                nxt_acc = NAEU_ACC_RST;
                            end
                            NAEU_OP_CLEAR_CARRY: begin
                                nxt_carry = 1'b0;
                            end
                            NAEU_OP_SET_CARRY: begin
                                nxt_carry = 1'b1;
                            end
                            // nop and other groups leave state alone
                            default: begin
                                nxt_acc = acc_ff;
                            end
                        endcase
                    end
                    if (nxt_skip) begin
                        nxt_state = NAEU_ST_SKIP;
                    end
                end
                default: begin
                    nxt_state = NAEU_ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            acc_ff      <= NAEU_ACC_RST;
            carry_ff    <= NAEU_CARRY_RST;
            skip_req_ff <= 1'b0;
            illegal_ff  <= 1'b0;
            pc_ff       <= NAEU_PC_RST;
            state_ff    <= NAEU_ST_EXEC;
        end else begin
            acc_ff      <= nxt_acc;
            carry_ff    <= nxt_carry;
            skip_req_ff <= nxt_skip;
            illegal_ff  <= nxt_illegal;
            pc_ff       <= nxt_pc;
            state_ff    <= nxt_state;
        end
    end
endmodule // naeu_exec

//--- verification/naeu_exec_assertions.sv
// checker for the nibble arithmetic execution unit
`timescale 1ns/1ps
module naeu_exec_chk (
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // instruction
    input wire logic        instr_valid,
    input wire logic [7:0]  opcode,
    // state
    input wire logic [3:0]  acc_ff,
    input wire logic        carry_ff,
    input wire logic        skip_req_ff,
    input wire logic [10:0] pc_ff,
    input wire logic        illegal_ff
);
    logic       pend_ff;
    logic       nxt_pend;
    logic       take;
    logic [3:0] imm;
    // a skip waits for the next valid op, even across idle cycles
    assign imm  = opcode[3:0];
    assign take = instr_valid & ~(skip_req_ff | pend_ff);
    always_comb nxt_pend = ~instr_valid & (skip_req_ff | pend_ff);
    always_ff @(posedge mclk or posedge reset)
        if (reset) pend_ff <= 1'b0;
        else pend_ff <= nxt_pend;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    a_pc_step: assert property (
        instr_valid |=> pc_ff == $past(pc_ff) + 11'h1) else $error("pc step");
    a_pc_hold: assert property (
        !instr_valid |=> $stable(pc_ff)) else $error("pc moved");
    a_skip_carry: assert property (
        take && (opcode == 8'h30 || opcode == 8'h10)
        |=> skip_req_ff == carry_ff) else $error("skip not carry");
    a_add_keep: assert property (
        take && opcode == 8'h31 |=> !skip_req_ff && $stable(carry_ff))
        else $error("add touched carry");
    a_add_ten: assert property (
        take && opcode == 8'h4a |=> acc_ff == $past(acc_ff) + 4'ha)
        else $error("add ten wrong");
    a_imm_add: assert property (
        take && opcode[7:4] == 4'h5 |=> $stable(carry_ff)
        && acc_ff == $past(acc_ff) + $past(imm)) else $error("imm add");
    a_comp_acc: assert property (
        take && opcode == 8'h40 |=> acc_ff == ~$past(acc_ff))
        else $error("complement");
    a_drop_op: assert property (
        instr_valid && !take |=> $stable(acc_ff) && $stable(carry_ff)
        && !skip_req_ff) else $error("discarded op acted");
    cover property (take && opcode == 8'h30 ##1 skip_req_ff);
    cover property (instr_valid && !take);
    cover property (illegal_ff);
endmodule // naeu_exec_chk

//--- verification/naeu_ram_mdl.sv
// behavioural data ram beside the unit
`timescale 1ns/1ps
module naeu_ram_mdl (
    // clock and write
    input  wire logic       mclk,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_data,
    // pointer and word
    input  wire logic [6:0] addr,
    output logic      [3:0] word
);
    logic [3:0] mem [128];
    assign word = mem[{addr[6:4], addr[3:0]}];
    always @(posedge mclk)
        if (wr_en) mem[addr] <= wr_data;
endmodule // naeu_ram_mdl

//--- verification/nibble_arith_exec_unit_test.sv
// self-checking bench for the nibble arithmetic execution unit
`timescale 1ns/1ps
module nibble_arith_exec_unit_test;
    import naeu_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, instr_valid = 1'b0;
    logic        ram_wr_en = 1'b0, carry_ff, skip_req_ff, illegal_ff;
    logic        ec = 1'b0, sk = 1'b0;
    logic [7:0]  opcode = 8'h00, op;
    logic [6:0]  ram_ptr = 7'h00;
    logic [3:0]  ram_wr_data = 4'h0, acc_ff, word, ea = 4'h0;
    logic [10:0] pc_ff, epc = 11'h000;
    int          failures = 0, num_checks = 0, seed = 38807;
    logic [7:0]  ops [11] = '{8'h30, 8'h31, 8'h4a, 8'h50, 8'h10, 8'h40,
                              8'h02, 8'h00, 8'h32, 8'h22, 8'h44};
    logic [7:0]  edge_ops [6] = '{8'h22, 8'h30, 8'h44, 8'h5f, 8'h50, 8'h10};
    always #10 mclk = ~mclk;
    naeu_exec uut (.mclk(mclk), .reset(reset), .instr_valid(instr_valid),
        .opcode(opcode), .ram_ptr(ram_ptr), .ram_wr_en(ram_wr_en),
        .ram_wr_data(ram_wr_data), .acc_ff(acc_ff), .carry_ff(carry_ff),
        .skip_req_ff(skip_req_ff), .pc_ff(pc_ff), .illegal_ff(illegal_ff));
    naeu_ram_mdl ram_mdl (.mclk(mclk), .wr_en(ram_wr_en),
        .wr_data(ram_wr_data), .addr(ram_ptr), .word(word));
    // returns skip, carry, acc
    function automatic logic [5:0] expect_op(input logic [7:0] op,
        input logic [3:0] a, input logic c, input logic [3:0] m);
        logic [4:0] s, t, u;
        s = {1'b0, a} + {4'h0, c} + {1'b0, m};
        t = {1'b0, a} + {1'b0, op[3:0]};
        u = {1'b0, ~a} + {4'h0, c} + {1'b0, m};
        casez (op)
            8'h30: return {s[4], s};
            8'h31: return {1'b0, c, a + m};
            8'h4a: return {1'b0, c, a + 4'ha};
            8'h5?: return {t[4], c, t[3:0]};
            8'h10: return {u[4], u};
            8'h40: return {1'b0, c, ~a};
            8'h02: return {1'b0, c, a ^ m};
            8'h00: return {1'b0, c, 4'h0};
            8'h32: return {2'b00, a};
            8'h22: return {2'b01, a};
            default: return {1'b0, c, a};
        endcase
    endfunction
    task automatic chk(input string name, input logic [10:0] exp, seen);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // load the word, let the registered read settle, then issue the op
    task automatic step(input logic [7:0] o, input logic [6:0] p,
                        input logic [3:0] d);
        logic [5:0] r;
        @(posedge mclk);
        ram_wr_en   <= 1'b1;
        ram_ptr     <= p;
        ram_wr_data <= d;
        @(posedge mclk);
        ram_wr_en <= 1'b0;
        @(posedge mclk);
        instr_valid <= 1'b1;
        opcode      <= o;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        r   = sk ? {1'b0, ec, ea} : expect_op(o, ea, ec, word);
        epc = epc + 11'h1;
        chk("state", {5'h0, r},
            {5'h0, skip_req_ff, carry_ff, acc_ff});
        chk("pc", epc, pc_ff);
        if (!sk) begin
            chk("illegal", {10'h0, o == 8'h50},
                {10'h0, illegal_ff});
        end
        {sk, ec, ea} = r;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        foreach (edge_ops[i]) step(edge_ops[i], 7'h7f, 4'hf);
        foreach (ops[i]) step(ops[i], 7'(i), 4'h9);
        repeat (200) begin
            op = ops[$unsigned($random(seed)) % 11];
            if (op == 8'h50) op[3:0] = 4'($random(seed));
            step(op, 7'($random(seed)), 4'($random(seed)));
        end
        print_verdict();
    end
    // about four and a half times the expected run
    initial begin
        #80000;
        failures++;
        print_verdict();
    end
endmodule // nibble_arith_exec_unit_test
bind naeu_exec naeu_exec_chk u_chk (.mclk(mclk), .reset(reset),
    .instr_valid(instr_valid), .opcode(opcode), .acc_ff(acc_ff),
    .carry_ff(carry_ff), .skip_req_ff(skip_req_ff), .pc_ff(pc_ff),
    .illegal_ff(illegal_ff));
